// ---- hw/gpmux_map.svh ----
/*
 * gpmux_map.svh : constants of the pin-function multiplexer (widths, reset
 * values, select-field positions and codes).
 * assumes: included by the package and the mux module, by bare name.
 */
`ifndef GPMUX_MAP_SVH
`define GPMUX_MAP_SVH

// ----------------------------------------------------------------------------
// port widths
// ----------------------------------------------------------------------------
`define GPMUX_PA_W        8
`define GPMUX_PB_W        8
`define GPMUX_PC_W        8
`define GPMUX_PD_W        4
`define GPMUX_SEL_W       16

// ----------------------------------------------------------------------------
// reset values of the per-pin peripheral enables and the select register
// ----------------------------------------------------------------------------
`define GPMUX_PA_PEN_RST  8'h80
`define GPMUX_PB_PEN_RST  8'h00
`define GPMUX_PC_PEN_RST  8'hFF
`define GPMUX_PD_PEN_RST  4'hF
`define GPMUX_SEL_RST     16'h0000

// ----------------------------------------------------------------------------
// select register field positions (low bit of each field)
// ----------------------------------------------------------------------------
`define GPMUX_F_A4        0
`define GPMUX_F_A5        2
`define GPMUX_F_B0        4
`define GPMUX_F_B1        5
`define GPMUX_F_B2        6
`define GPMUX_F_B3        7
`define GPMUX_F_B4        8
`define GPMUX_F_B5        9
`define GPMUX_F_B6        10
`define GPMUX_F_B7        11

// ----------------------------------------------------------------------------
// three-way field codes
// ----------------------------------------------------------------------------
`define GPMUX_SEL3_PWM    2'h0
`define GPMUX_SEL3_FAULT  2'h1
`define GPMUX_SEL3_TIMER  2'h2

`endif

// ---- hw/gpmux_pin_function_mux.sv ----
/*
 * gpmux_pin_function_mux.sv : routes the pads of ports A..D to port bits or
 * peripheral signals, with registered select and enable state.
 * assumes: one clock core_clk (50 MHz), synchronous active-high rst, pads
 * given as in/out/oe triplets; peripherals and port logic on core_clk.
 */
`include "gpmux_map.svh"

module gpmux_pin_function_mux
(
   input  wire logic                 core_clk,          // system bus clock
   input  wire logic                 rst,               // sync reset, high
   input  wire logic                 clk_en,            // freezes state when low
   // configuration
   input  wire logic                 cfg_we,            // load enables and select
   input  wire gpmux_pkg::gpmux_sel_t peripheral_select_register_wd, // select value
   input  wire gpmux_pkg::gpmux_byte_t pa_pen_wd,       // port A peripheral enables
   input  wire gpmux_pkg::gpmux_byte_t pb_pen_wd,       // port B peripheral enables
   input  wire gpmux_pkg::gpmux_byte_t pc_pen_wd,       // port C peripheral enables
   input  wire gpmux_pkg::gpmux_nib_t  pd_pen_wd,       // port D peripheral enables
   input  wire logic                 pll_ext_clk_en,    // from oscillator_clock_block
   output gpmux_pkg::gpmux_sel_t     peripheral_select_register, // select state
   output gpmux_pkg::gpmux_byte_t    pa_pen,            // current enables A
   output gpmux_pkg::gpmux_byte_t    pb_pen,            // current enables B
   output gpmux_pkg::gpmux_byte_t    pc_pen,            // current enables C
   output gpmux_pkg::gpmux_nib_t     pd_pen,            // current enables D
   // port logic side (per-bit out, out-enable, in)
   input  wire gpmux_pkg::gpmux_byte_t pa_do,           // port A data out
   input  wire gpmux_pkg::gpmux_byte_t pa_doe,          // port A drive enable
   output gpmux_pkg::gpmux_byte_t    pa_di,             // port A data in
   input  wire gpmux_pkg::gpmux_byte_t pb_do,           // port B data out
   input  wire gpmux_pkg::gpmux_byte_t pb_doe,          // port B drive enable
   output gpmux_pkg::gpmux_byte_t    pb_di,             // port B data in
   input  wire gpmux_pkg::gpmux_byte_t pc_do,           // port C data out
   input  wire gpmux_pkg::gpmux_byte_t pc_doe,          // port C drive enable
   output gpmux_pkg::gpmux_byte_t    pc_di,             // port C data in
   input  wire gpmux_pkg::gpmux_nib_t  pd_do,           // port D data out
   input  wire gpmux_pkg::gpmux_nib_t  pd_doe,          // port D drive enable
   output gpmux_pkg::gpmux_nib_t     pd_di,             // port D data in
   // peripheral side
   input  wire logic [5:0]           pwm_out,           // pwm outputs 0..5
   output logic [3:0]                fault_in,          // fault inputs 0..3
   input  wire logic [3:0]           timer_do,          // timer channel outputs
   input  wire logic [3:0]           timer_doe,         // timer channel drive enables
   output logic [3:0]                timer_di,          // timer channel inputs
   output logic                      port_a_pin_seven_rst_n, // reset input, low active
   input  wire logic                 spi_sclk_o,        // spi clock out
   input  wire logic                 spi_sclk_oe,       // spi clock drive
   output logic                      spi_sclk_i,        // spi clock in
   input  wire logic                 spi_ss_o,          // spi slave select out
   input  wire logic                 spi_ss_oe,         // spi slave select drive
   output logic                      spi_ss_i,          // spi slave select in
   input  wire logic                 spi_miso_o,        // spi master-in out (slave)
   input  wire logic                 spi_miso_oe,       // spi master-in drive
   output logic                      spi_miso_i,        // spi master-in in
   input  wire logic                 spi_mosi_o,        // spi master-out out
   input  wire logic                 spi_mosi_oe,       // spi master-out drive
   output logic                      spi_mosi_i,        // spi master-out in
   input  wire logic                 i2c_scl_oe,        // i2c clock pull low
   output logic                      i2c_scl_i,         // i2c clock in
   input  wire logic                 i2c_sda_oe,        // i2c data pull low
   output logic                      i2c_sda_i,         // i2c data in
   input  wire logic                 uart_txd,          // uart transmit data
   output logic                      uart_rxd,          // uart receive data
   input  wire logic                 clock_output,      // internal clock out
   output logic                      external_clock_input, // clock in from B6
   output gpmux_pkg::gpmux_byte_t    analog_in_en,      // port C pads to adc
   input  wire logic                 jtag_tdo,          // jtag data out
   input  wire logic                 jtag_tdo_oe,       // jtag data out drive
   output logic [2:0]                jtag_in,           // tdi, tck, tms
   // pads
   input  wire gpmux_pkg::gpmux_byte_t pad_a_in,        // port A pads in
   output gpmux_pkg::gpmux_byte_t    pad_a_out,         // port A pads out
   output gpmux_pkg::gpmux_byte_t    pad_a_oe,          // port A pads drive
   input  wire gpmux_pkg::gpmux_byte_t pad_b_in,        // port B pads in
   output gpmux_pkg::gpmux_byte_t    pad_b_out,         // port B pads out
   output gpmux_pkg::gpmux_byte_t    pad_b_oe,          // port B pads drive
   input  wire gpmux_pkg::gpmux_byte_t pad_c_in,        // port C pads in
   output gpmux_pkg::gpmux_byte_t    pad_c_out,         // port C pads out
   output gpmux_pkg::gpmux_byte_t    pad_c_oe,          // port C pads drive
   input  wire gpmux_pkg::gpmux_nib_t  pad_d_in,        // port D pads in
   output gpmux_pkg::gpmux_nib_t     pad_d_out,         // port D pads out
   output gpmux_pkg::gpmux_nib_t     pad_d_oe           // port D pads drive
);
   import gpmux_pkg::*;

   // -------------------------------------------------------------------------
   // configuration state
   // -------------------------------------------------------------------------
   gpmux_sel_t  sel_r;
   gpmux_byte_t pa_pen_r;
   gpmux_byte_t pb_pen_r;
   gpmux_byte_t pc_pen_r;
   gpmux_nib_t  pd_pen_r;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sel_r    <= `GPMUX_SEL_RST;
         pa_pen_r <= `GPMUX_PA_PEN_RST;
         pb_pen_r <= `GPMUX_PB_PEN_RST;
         pc_pen_r <= `GPMUX_PC_PEN_RST;
         pd_pen_r <= `GPMUX_PD_PEN_RST;
      end
      else if (clk_en && cfg_we)
      begin
         sel_r    <= peripheral_select_register_wd;
         pa_pen_r <= pa_pen_wd;
         pb_pen_r <= pb_pen_wd;
         pc_pen_r <= pc_pen_wd;
         pd_pen_r <= pd_pen_wd;
      end
   end

   assign peripheral_select_register = sel_r;
   assign pa_pen = pa_pen_r;
   assign pb_pen = pb_pen_r;
   assign pc_pen = pc_pen_r;
   assign pd_pen = pd_pen_r;

   // -------------------------------------------------------------------------
   // pad input synchronisers (two flops, nothing reads the first)
   // -------------------------------------------------------------------------
   gpmux_byte_t a_s1_r, a_s2_r, b_s1_r, b_s2_r, c_s1_r, c_s2_r;
   gpmux_nib_t  d_s1_r, d_s2_r;

   always_ff @(posedge core_clk)
   begin
      if (clk_en)
      begin
         a_s1_r <= pad_a_in;
         a_s2_r <= a_s1_r;
         b_s1_r <= pad_b_in;
         b_s2_r <= b_s1_r;
         c_s1_r <= pad_c_in;
         c_s2_r <= c_s1_r;
         d_s1_r <= pad_d_in;
         d_s2_r <= d_s1_r;
      end
   end

   // -------------------------------------------------------------------------
   // select fields
   // -------------------------------------------------------------------------
   wire [1:0] sel_a4 = sel_r[`GPMUX_F_A4 +: 2];
   wire [1:0] sel_a5 = sel_r[`GPMUX_F_A5 +: 2];
   wire sel_b0 = sel_r[`GPMUX_F_B0];
   wire sel_b1 = sel_r[`GPMUX_F_B1];
   wire sel_b2 = sel_r[`GPMUX_F_B2];
   wire sel_b3 = sel_r[`GPMUX_F_B3];
   wire sel_b4 = sel_r[`GPMUX_F_B4];
   wire sel_b5 = sel_r[`GPMUX_F_B5];
   wire sel_b6 = sel_r[`GPMUX_F_B6];
   wire sel_b7 = sel_r[`GPMUX_F_B7];

   // peripheral-side drive per pin; code 3 on a three-way field is unused
   // and leaves the pad undriven rather than guessing a function
   gpmux_byte_t pa_po, pa_poe, pb_po, pb_poe;

   assign pa_po[3:0]  = pwm_out[3:0];
   assign pa_poe[2:0] = 3'h7;
   assign pa_poe[3]   = 1'h1;
   assign pa_po[4]  = (sel_a4 == `GPMUX_SEL3_PWM) ? pwm_out[4] : timer_do[2];
   assign pa_poe[4] = (sel_a4 == `GPMUX_SEL3_PWM) | ((sel_a4 == `GPMUX_SEL3_TIMER) & timer_doe[2]);
   assign pa_po[5]  = (sel_a5 == `GPMUX_SEL3_PWM) ? pwm_out[5] : timer_do[3];
   assign pa_poe[5] = (sel_a5 == `GPMUX_SEL3_PWM) | ((sel_a5 == `GPMUX_SEL3_TIMER) & timer_doe[3]);
   assign pa_po[6]  = 1'h0;
   assign pa_poe[6] = 1'h0;
   assign pa_po[7]  = 1'h0;                            // reset pin is input only
   assign pa_poe[7] = 1'h0;

   // i2c lines are open drain: drive low only
   assign pb_po[0]  = sel_b0 ? 1'h0 : spi_sclk_o;
   assign pb_poe[0] = sel_b0 ? i2c_scl_oe : spi_sclk_oe;
   assign pb_po[1]  = sel_b1 ? 1'h0 : spi_ss_o;
   assign pb_poe[1] = sel_b1 ? i2c_sda_oe : spi_ss_oe;
   assign pb_po[2]  = sel_b2 ? timer_do[2] : spi_miso_o;
   assign pb_poe[2] = sel_b2 ? timer_doe[2] : spi_miso_oe;
   assign pb_po[3]  = sel_b3 ? timer_do[3] : spi_mosi_o;
   assign pb_poe[3] = sel_b3 ? timer_doe[3] : spi_mosi_oe;
   assign pb_po[4]  = sel_b4 ? clock_output : timer_do[0];
   assign pb_poe[4] = sel_b4 ? 1'h1 : timer_doe[0];
   assign pb_po[5]  = timer_do[1];
   assign pb_poe[5] = sel_b5 ? 1'h0 : timer_doe[1];
   assign pb_po[6]  = 1'h0;
   assign pb_poe[6] = sel_b6 ? i2c_sda_oe : 1'h0;
   assign pb_po[7]  = sel_b7 ? 1'h0 : uart_txd;
   assign pb_poe[7] = sel_b7 ? i2c_scl_oe : 1'h1;

   // -------------------------------------------------------------------------
   // pad drive: port bit when enable clear, peripheral when set
   // -------------------------------------------------------------------------
   wire  [3:0] pd_po  = {1'h0, 1'h0, jtag_tdo, 1'h0};
   wire  [3:0] pd_poe = {1'h0, 1'h0, jtag_tdo_oe, 1'h0};
   // a6 and a3 have no pad; their port bits still loop back internally
   wire  [7:0] pa_bonded = 8'hB7;

   assign pad_a_out = (pa_pen_r & pa_po) | (~pa_pen_r & pa_do);
   assign pad_a_oe  = ((pa_pen_r & pa_poe) | (~pa_pen_r & pa_doe)) & pa_bonded;
   assign pad_b_out = (pb_pen_r & pb_po) | (~pb_pen_r & pb_do);
   assign pad_b_oe  = (pb_pen_r & pb_poe) | (~pb_pen_r & pb_doe);
   // analog pins never drive in peripheral mode
   assign pad_c_out = ~pc_pen_r & pc_do;
   assign pad_c_oe  = ~pc_pen_r & pc_doe;
   assign pad_d_out = (pd_pen_r & pd_po) | (~pd_pen_r & pd_do);
   assign pad_d_oe  = (pd_pen_r & pd_poe) | (~pd_pen_r & pd_doe);
   assign analog_in_en = pc_pen_r;

   // -------------------------------------------------------------------------
   // input routing
   // -------------------------------------------------------------------------
   wire [7:0] a_in = (a_s2_r & pa_bonded) | (pa_do & ~pa_bonded);
   assign pa_di = a_in;
   assign pb_di = b_s2_r;
   assign pc_di = c_s2_r;
   assign pd_di = d_s2_r;

   // an unselected peripheral input sits at its idle level
   wire a4_en = pa_pen_r[4];
   wire a5_en = pa_pen_r[5];
   assign fault_in[0] = 1'h0;                                                   // A6 unbonded
   assign fault_in[1] = a4_en & (sel_a4 == `GPMUX_SEL3_FAULT) & a_in[4];
   assign fault_in[2] = a5_en & (sel_a5 == `GPMUX_SEL3_FAULT) & a_in[5];
   assign fault_in[3] = pb_pen_r[5] & sel_b5 & b_s2_r[5];
   assign timer_di[0] = pb_pen_r[4] & ~sel_b4 & b_s2_r[4];
   assign timer_di[1] = pb_pen_r[5] & ~sel_b5 & b_s2_r[5];
   assign timer_di[2] = (a4_en & (sel_a4 == `GPMUX_SEL3_TIMER) & a_in[4])
                      | (pb_pen_r[2] & sel_b2 & b_s2_r[2]);
   assign timer_di[3] = (a5_en & (sel_a5 == `GPMUX_SEL3_TIMER) & a_in[5])
                      | (pb_pen_r[3] & sel_b3 & b_s2_r[3]);
   assign port_a_pin_seven_rst_n = ~pa_pen_r[7] | a_s2_r[7];
   assign spi_sclk_i = pb_pen_r[0] & ~sel_b0 & b_s2_r[0];
   assign spi_ss_i   = ~(pb_pen_r[1] & ~sel_b1) | b_s2_r[1];
   assign spi_miso_i = pb_pen_r[2] & ~sel_b2 & b_s2_r[2];
   assign spi_mosi_i = pb_pen_r[3] & ~sel_b3 & b_s2_r[3];
   assign i2c_scl_i  = ~((pb_pen_r[0] & sel_b0) | (pb_pen_r[7] & sel_b7))
                     | ((~(pb_pen_r[0] & sel_b0) | b_s2_r[0])
                      & (~(pb_pen_r[7] & sel_b7) | b_s2_r[7]));
   assign i2c_sda_i  = ~((pb_pen_r[1] & sel_b1) | (pb_pen_r[6] & sel_b6))
                     | ((~(pb_pen_r[1] & sel_b1) | b_s2_r[1])
                      & (~(pb_pen_r[6] & sel_b6) | b_s2_r[6]));
   assign uart_rxd   = ~(pb_pen_r[6] & ~sel_b6) | b_s2_r[6];
   // clock-in path ignores the select register and the port B enable
   assign external_clock_input = pll_ext_clk_en & b_s2_r[6];
   assign jtag_in = pd_pen_r[3] ? {d_s2_r[0], d_s2_r[2], d_s2_r[3]} : 3'h0;

endmodule : gpmux_pin_function_mux

// ---- hw/gpmux_pkg.sv ----
/*
 * gpmux_pkg.sv : types of the pin-function multiplexer.
 * assumes: gpmux_map.svh is on the include path.
 */
`include "gpmux_map.svh"

package gpmux_pkg;
   typedef logic [`GPMUX_SEL_W-1:0] gpmux_sel_t;
   typedef logic [`GPMUX_PA_W-1:0]  gpmux_byte_t;
   typedef logic [`GPMUX_PD_W-1:0]  gpmux_nib_t;
endpackage : gpmux_pkg

// ---- testbench/gpio_pin_function_mux_test.sv ----
/* gpio_pin_function_mux_test.sv : self-checking random bench of the pin-function mux.
   assumes: design package and header on the include path; board model and checker compiled first. */
module gpio_pin_function_mux_test;
   timeunit 1ns;
   timeprecision 1ps;
   import gpmux_pkg::*;
   logic        core_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, cfg_we = 1'h0, pll = 1'h0;
   logic        ext_clk, rxd, a7_rst_n;
   logic [7:0]  paw = 8'h00, pbw = 8'h00, pcw = 8'h00;
   logic [3:0]  pdw = 4'h0;
   logic [15:0] sw = 16'h0000;
   logic [27:0] pv = 28'h0, bv = 28'h0, be = 28'h0;
   logic [55:0] gv = 56'h0;
   gpmux_sel_t  sel_q;
   gpmux_byte_t pa_pen, pb_pen, pc_pen, pb_di, analog_in_en, pad_a_in, pad_a_out, pad_a_oe, pad_b_in, pad_b_out;
   gpmux_byte_t pad_b_oe, pad_c_in, pad_c_out, pad_c_oe, pa_di;
   logic [8:0]  pi;
   logic [2:0]  jt;
   gpmux_nib_t  pd_pen, pad_d_in, pad_d_out, pad_d_oe;
   int          err_total = 0, samples_checked = 0, cycles = 0;

   gpmux_pin_function_mux gpmux_pin_function_mux_inst (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
      .cfg_we(cfg_we), .peripheral_select_register_wd(sw), .pa_pen_wd(paw), .pb_pen_wd(pbw), .pc_pen_wd(pcw),
      .pd_pen_wd(pdw), .pll_ext_clk_en(pll), .peripheral_select_register(sel_q), .pa_pen(pa_pen),
      .pb_pen(pb_pen), .pc_pen(pc_pen), .pd_pen(pd_pen), .pa_do(gv[7:0]), .pa_doe(gv[15:8]), .pa_di(pa_di),
      .pb_do(gv[23:16]), .pb_doe(gv[31:24]), .pb_di(pb_di), .pc_do(gv[39:32]), .pc_doe(gv[47:40]), .pc_di(),
      .pd_do(gv[51:48]), .pd_doe(gv[55:52]), .pd_di(), .pwm_out(pv[5:0]), .fault_in(pi[3:0]), .timer_do(pv[9:6]),
      .timer_doe(pv[13:10]), .timer_di(pi[7:4]), .port_a_pin_seven_rst_n(a7_rst_n), .spi_sclk_o(pv[14]),
      .spi_sclk_oe(pv[15]), .spi_sclk_i(pi[8]), .spi_ss_o(pv[16]), .spi_ss_oe(pv[17]), .spi_ss_i(),
      .spi_miso_o(pv[18]), .spi_miso_oe(pv[19]), .spi_miso_i(), .spi_mosi_o(pv[20]), .spi_mosi_oe(pv[21]),
      .spi_mosi_i(), .i2c_scl_oe(pv[22]), .i2c_scl_i(), .i2c_sda_oe(pv[23]), .i2c_sda_i(), .uart_txd(pv[24]),
      .uart_rxd(rxd), .clock_output(pv[25]), .external_clock_input(ext_clk), .analog_in_en(analog_in_en),
      .jtag_tdo(pv[26]), .jtag_tdo_oe(pv[27]), .jtag_in(jt), .pad_a_in(pad_a_in), .pad_a_out(pad_a_out),
      .pad_a_oe(pad_a_oe), .pad_b_in(pad_b_in), .pad_b_out(pad_b_out), .pad_b_oe(pad_b_oe), .pad_c_in(pad_c_in),
      .pad_c_out(pad_c_out), .pad_c_oe(pad_c_oe), .pad_d_in(pad_d_in), .pad_d_out(pad_d_out), .pad_d_oe(pad_d_oe));
   gpmux_board_model #(.W(28)) gpmux_board_model_inst (.core_clk(core_clk), .bval(bv), .ben(be),
      .pad_out({pad_d_out, pad_c_out, pad_b_out, pad_a_out}), .pad_oe({pad_d_oe, pad_c_oe, pad_b_oe, pad_a_oe}),
      .pad_in({pad_d_in, pad_c_in, pad_b_in, pad_a_in}));

   initial
   begin
      forever #10 core_clk = ~core_clk;
   end
   // the whole run needs 223 cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_total++;
         end_sim();
      end
   end
   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task end_sim();
      $display("counts: %0d compared, %0d mismatched", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   task automatic rnd();
      pv = 28'($urandom);
      bv = 28'($urandom);
      be = 28'($urandom);
      gv = {24'($urandom), $urandom};
      pll = 1'($urandom);
   endtask : rnd
   // expected {oe, out} of port A; a peripheral input leaves its pad undriven
   function automatic logic [15:0] exp_a();
      logic [7:0] o, q;
      o = gv[7:0];
      q = gv[15:8];
      for (int i = 0; i < 3; i++) if (paw[i]) {o[i], q[i]} = {pv[i], 1'h1};
      if (paw[4]) {o[4], q[4]} = sw[1:0] == 2'h0 ? {pv[4], 1'h1} : (sw[1:0] == 2'h2 ? {pv[8], pv[12]} : 2'h0);
      if (paw[5]) {o[5], q[5]} = sw[3:2] == 2'h0 ? {pv[5], 1'h1} : (sw[3:2] == 2'h2 ? {pv[9], pv[13]} : 2'h0);
      q[3] = 1'h0;
      q[6] = 1'h0;
      if (paw[7]) q[7] = 1'h0;
      return {q, o};
   endfunction : exp_a
   function automatic logic [15:0] exp_b();
      logic [7:0] o, q;
      o = gv[23:16];
      q = gv[31:24];
      if (pbw[0]) {o[0], q[0]} = sw[4] ? {1'h0, pv[22]} : {pv[14], pv[15]};
      if (pbw[1]) {o[1], q[1]} = sw[5] ? {1'h0, pv[23]} : {pv[16], pv[17]};
      if (pbw[2]) {o[2], q[2]} = sw[6] ? {pv[8], pv[12]} : {pv[18], pv[19]};
      if (pbw[3]) {o[3], q[3]} = sw[7] ? {pv[9], pv[13]} : {pv[20], pv[21]};
      if (pbw[4]) {o[4], q[4]} = sw[8] ? {pv[25], 1'h1} : {pv[6], pv[10]};
      if (pbw[5]) {o[5], q[5]} = sw[9] ? 2'h0 : {pv[7], pv[11]};
      if (pbw[6]) {o[6], q[6]} = sw[10] ? {1'h0, pv[23]} : 2'h0;
      if (pbw[7]) {o[7], q[7]} = sw[11] ? {1'h0, pv[22]} : {pv[24], 1'h1};
      return {q, o};
   endfunction : exp_b
   task automatic check();
      logic [15:0] ea, eb;
      logic [7:0]  m;
      ea = exp_a();
      eb = exp_b();
      m = pad_b_oe | be[15:8];
      chk({pa_pen, pb_pen, pc_pen, pd_pen, sel_q}, {paw, pbw, pcw, pdw, sw});
      chk(pad_a_oe, ea[15:8]);
      chk(pad_a_out & ea[15:8], ea[7:0] & ea[15:8]);
      chk(pad_b_oe, eb[15:8]);
      chk(pad_b_out & eb[15:8], eb[7:0] & eb[15:8]);
      chk({pad_c_oe, pad_d_oe}, {gv[47:40] & ~pcw, (gv[55:52] & ~pdw) | {2'h0, pdw[1] & pv[27], 1'h0}});
      chk(pb_di & m, pad_b_in & m);
      if (pll && m[6]) chk(ext_clk, pad_b_in[6]);
      if (pbw[6] && !sw[10] && m[6]) chk(rxd, pad_b_in[6]);
      chk(a7_rst_n, !paw[7] | pad_a_in[7]);
      chk({pa_di[6], pa_di[3]}, {gv[6], gv[3]});
      chk(jt, pdw[3] ? {pad_d_in[0], pad_d_in[2], pad_d_in[3]} : 3'h0);
      chk(pi[1], paw[4] & sw[1:0] == 2'h1 & pad_a_in[4]);
      chk(pi[2], paw[5] & sw[3:2] == 2'h1 & pad_a_in[5]);
      chk({pi[3], pi[0]}, {pbw[5] & sw[9] & pad_b_in[5], 1'h0});
      chk(pi[5:4], {pbw[5] & !sw[9] & pad_b_in[5], pbw[4] & !sw[8] & pad_b_in[4]});
      chk(pi[6], paw[4] & sw[1:0] == 2'h2 & pad_a_in[4] | pbw[2] & sw[6] & pad_b_in[2]);
      chk(pi[7], paw[5] & sw[3:2] == 2'h2 & pad_a_in[5] | pbw[3] & sw[7] & pad_b_in[3]);
      chk(pi[8], pbw[0] & !sw[4] & pad_b_in[0]);
   endtask : check
   // two back-to-back writes; only the second may stay
   task automatic cfg(input logic [15:0] s, input logic [27:0] pens);
      cfg_we = 1'h1;
      {paw, pbw, pcw, pdw} = 28'($urandom);
      sw = 16'($urandom);
      step(1);
      {paw, pbw, pcw, pdw} = pens;
      sw = s;
      step(1);
      cfg_we = 1'h0;
      step(3);
   endtask : cfg
   task automatic chk_rst();
      chk(sel_q, 16'h0000);
      chk({pa_pen, pb_pen, pc_pen, pd_pen}, {8'h80, 8'h00, 8'hFF, 4'hF});
      chk(pad_b_oe, gv[31:24]);
      chk(analog_in_en, 8'hFF);
   endtask : chk_rst
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial
   begin
      void'($urandom(32'h9BE625B6));
      step(10);
      rnd();
      step(10);
      rst = 1'h0;
      chk_rst();
      $display("reset state test done");
      for (int i = 0; i < 40; i++)
      begin
         rnd();
         cfg(i == 0 ? 16'h0000 : (i == 1 ? 16'hFFFF : 16'($urandom)), i < 2 ? 28'hFFFFFFF : 28'($urandom));
         check();
      end
      $display("random routing test done");
      clk_en = 1'h0;
      cfg_we = 1'h1;
      paw = ~paw;
      sw = ~sw;
      step(1);
      clk_en = 1'h1;
      cfg_we = 1'h0;
      step(1);
      chk({pa_pen, sel_q}, {~paw, ~sw});
      $display("frozen write test done");
      rst = 1'h1;
      step(1);
      rst = 1'h0;
      chk_rst();
      $display("second reset test done");
      end_sim();
   end
endmodule : gpio_pin_function_mux_test

// ---- testbench/gpmux_board_model.sv ----
/* gpmux_board_model.sv : board side of the pads, resolving the device drive against external drivers.
   assumes: the bench concatenates all pad vectors into one; one clock core_clk. */
module gpmux_board_model #(
   parameter int W = 8 // number of pads modelled
)
(
   input  wire logic         core_clk, // system clock
   input  wire logic [W-1:0] pad_out,  // device drive value
   input  wire logic [W-1:0] pad_oe,   // device drives pad
   input  wire logic [W-1:0] bval,     // board drive value
   input  wire logic [W-1:0] ben,      // board drives pad
   output logic      [W-1:0] pad_in    // resolved pad level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [W-1:0] flip_r = {W{1'h0}};
   // floating pads toggle every cycle so a stale level never passes for a driven one
   always @(posedge core_clk) flip_r <= ~flip_r;
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ben & bval) | (~pad_oe & ~ben & flip_r);
endmodule : gpmux_board_model

// ---- testbench/gpmux_sva.sv ----
/* gpmux_sva.sv : port checker of the pin-function mux, bound into every instance.
   assumes: one clock core_clk, synchronous active-high rst, pad inputs resolved outside. */
module gpmux_sva
   import gpmux_pkg::*;
(
   input wire logic        core_clk, rst, clk_en, cfg_we, pll_ext_clk_en,             // clock and control
   input wire logic        spi_sclk_o, spi_sclk_oe, external_clock_input,             // single lines
   input wire gpmux_sel_t  peripheral_select_register, peripheral_select_register_wd, // select
   input wire gpmux_byte_t pa_pen, pb_pen, pc_pen, pa_pen_wd, pb_pen_wd, analog_in_en, // enables
   input wire gpmux_byte_t pb_do, pb_doe, pb_di, pad_a_out, pad_a_oe, pad_b_in, pad_b_out, pad_b_oe, // pads
   input wire gpmux_nib_t  pd_pen,                                                    // port D enables
   input wire logic [5:0]  pwm_out,                                                   // pwm drives
   input wire logic [3:0]  timer_do, timer_doe                                        // timer drives
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------------
   // configuration state
   // ------------------------------------------------------------------
   chk_reset_vals: assert property ($fell(rst) |-> peripheral_select_register == 16'h0000 &&
      pa_pen == 8'h80 && pb_pen == 8'h00 && pc_pen == 8'hFF && pd_pen == 4'hF) else $error("bad reset state");
   chk_cfg_load: assert property (clk_en && cfg_we |=> pb_pen == $past(pb_pen_wd) &&
      pa_pen == $past(pa_pen_wd) && peripheral_select_register == $past(peripheral_select_register_wd))
      else $error("config not loaded");
   chk_cfg_hold: assert property (!(clk_en && cfg_we) |=> $stable(peripheral_select_register) &&
      $stable(pb_pen) && $stable(pa_pen)) else $error("config changed without a write");
   // ------------------------------------------------------------------
   // routing
   // ------------------------------------------------------------------
   chk_gpio_b: assert property (pb_pen == 8'h00 |-> pad_b_oe == pb_doe &&
      (pad_b_out & pb_doe) == (pb_do & pb_doe)) else $error("port B not gpio");
   chk_sclk_route: assert property (pb_pen[0] && !peripheral_select_register[4] |->
      pad_b_out[0] == spi_sclk_o && pad_b_oe[0] == spi_sclk_oe) else $error("B0 not spi clock");
   chk_a4_timer: assert property (pa_pen[4] && peripheral_select_register[1:0] == 2'h2 |->
      pad_a_out[4] == timer_do[2] && pad_a_oe[4] == timer_doe[2]) else $error("A4 not timer 2");
   chk_a5_pwm: assert property (pa_pen[5] && peripheral_select_register[3:2] == 2'h0 |->
      pad_a_out[5] == pwm_out[5] && pad_a_oe[5] == 1'h1) else $error("A5 not pwm 5");
   chk_no_pad: assert property ((pad_a_oe & 8'h48) == 8'h00 && !(pa_pen[7] && pad_a_oe[7]))
      else $error("unbonded or reset pad driven");
   chk_b_sync: assert property ($past(clk_en) && $past(clk_en, 2) |-> pb_di == $past(pad_b_in, 2))
      else $error("port B input path wrong");
   chk_ext_clk: assert property (pll_ext_clk_en && $past(clk_en) && $past(clk_en, 2) |->
      external_clock_input == $past(pad_b_in[6], 2)) else $error("external clock not from B6");
   chk_analog_en: assert property (analog_in_en == pc_pen)
      else $error("analog enable mismatch");
   cov_a4_unused: cover property (pa_pen[4] && peripheral_select_register[1:0] == 2'h3);
   cov_ext_clk: cover property (pll_ext_clk_en && pb_pen[6]);
   cov_refused: cover property (cfg_we && !clk_en);
endmodule : gpmux_sva

bind gpmux_pin_function_mux gpmux_sva gpmux_sva_inst (.*);
